// ### rtl/counter_pkg.sv
// constants for the 18-bit counter control block
`default_nettype none
package counter_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] cmp_low_addr    = 8'h10;
  localparam logic [7:0] cmp_mid_addr    = 8'h11;
  localparam logic [7:0] cmp_high_addr   = 8'h12;
  localparam logic [7:0] gate_timing_addr = 8'h13;
  localparam logic [7:0] ctl_one_addr    = 8'h14;
  localparam logic [7:0] ctl_two_addr    = 8'h15;
  localparam logic [7:0] status_addr     = 8'h16;
  localparam logic [7:0] power_addr      = 8'h18;
  // reset values
  localparam logic [7:0] ctl_one_reset   = 8'h88;
  localparam logic [7:0] ctl_two_reset   = 8'h02;
  localparam logic [7:0] status_reset    = 8'h00;
  localparam logic [7:0] gate_timing_reset = 8'h00;
  // field positions
  localparam int clear_bit      = 7;
  localparam int run_hi         = 6;
  localparam int run_lo         = 5;
  localparam int src_hi         = 4;
  localparam int src_lo         = 2;
  localparam int func_hi        = 1;
  localparam int func_lo        = 0;
  localparam int gsel_hi        = 6;
  localparam int gsel_lo        = 5;
  localparam int gedge_bit      = 4;
  localparam int gclk_hi        = 3;
  localparam int gclk_lo        = 2;
  localparam int gate_stat_bit  = 7;
  localparam int ovf_stat_bit   = 6;
  // control codes
  localparam logic [1:0] run_stop  = 2'h0;
  localparam logic [1:0] run_start = 2'h2;
  localparam logic [1:0] func_timer = 2'h0;
  localparam logic [1:0] func_pulse = 2'h2;
  localparam logic [1:0] func_freq  = 2'h3;
  localparam logic [2:0] src_fast   = 3'h0;
  localparam logic [2:0] src_fast_d7 = 3'h5;
  localparam logic [2:0] src_fast_d3 = 3'h6;
  localparam logic [2:0] src_event  = 3'h7;
  localparam logic [1:0] gate_pin   = 2'h0;
  localparam logic [1:0] gate_int   = 2'h1;
  localparam logic [1:0] gclk_rsvd  = 2'h3;
  // power modes
  typedef enum logic [1:0] {
    pm_normal = 2'b00,
    pm_idle   = 2'b01,
    pm_slow   = 2'b10,
    pm_sleep  = 2'b11
  } power_mode_t;
  localparam int gate_full = 16;
endpackage : counter_pkg
`default_nettype wire

// ### rtl/counter_ctl.sv
// 18-bit timer / event / pulse-width / frequency counter with Avalon-MM slave
// Summary of operation
// [RULE1] writing clear bit zero clears counter, overflow
// [RULE2] run field: 00 stop-clear, 10 start
// [RULE3] source field picks clock tap or pin
// [RULE4] function field: timer, pulse width, frequency
// [RULE5] software changes setup only while stopped
// [RULE6] low compare byte write blocks matching
// [RULE7] undivided fast clock allowed only limited
// [RULE8] compare location reads live counter
// [RULE9] compare at least one; read stopped
// [RULE10] software picks internal or pin source
// [RULE11] no read-modify-write on compare
// [RULE12] fast taps 101,110 dead in slow
// [RULE13] compare high upper six bits zero
// [RULE14] software writes fixed control-two bits
// [RULE15] gate select: pin or internal pulse
// [RULE16] edge field picks gate interrupt edges
// [RULE17] gate clock picks gate time base
// [RULE18] status bit 7 shows gate high; code shows it only while running in frequency mode
// [RULE19] status bit 6 overflow, others zero
// [RULE20] measurement wrap sets sticky overflow
// [RULE21] timer match interrupts and restarts count
// [RULE22] measurement interrupt on gate edges
`default_nettype none
module counter_ctl
  import counter_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // clock taps and pin
  input  wire logic        fs_tick,
  input  wire logic [4:0]  div_tap,
  input  wire logic [2:0]  gate_tap,
  input  wire logic        event_input_pin,
  // chip state
  input  wire logic        divider_stage_select,
  // interrupt to the processor
  output logic             counter_irq
);

  // registered state
  logic [7:0]  ctl_one, next_ctl_one;
  logic [7:0]  ctl_two, next_ctl_two;
  logic [7:0]  gate_timing_value, next_gate_timing_value;
  logic [17:0] compare_value, next_compare_value;
  logic [17:0] count, next_count;
  logic        overflow_monitor, next_overflow_monitor;
  logic        match_block, next_match_block;
  logic [1:0]  power_mode, next_power_mode;
  logic        gate_q, next_gate_q;
  logic        tick_q, next_tick_q;
  logic        pin_q, next_pin_q;
  logic        int_gate, next_int_gate;
  logic [3:0]  gate_cnt, next_gate_cnt;
  logic        gclk_q, next_gclk_q;
  logic        irq, next_irq;
  logic [31:0] rdata, next_rdata;
  logic        ack, next_ack;

  logic [1:0]  run_control;
  logic [2:0]  count_source_select;
  logic [1:0]  function_select;
  logic [1:0]  gate_pulse_select;
  logic        gate_irq_edge_select;
  logic [1:0]  gate_clock_select;
  logic        slow_mode;
  logic        src_clk;
  logic        src_ok;
  logic        gate;
  logic        gclk;
  logic        measuring;
  logic        running;
  logic        wr_hit;
  logic        gate_active_monitor;

  // byte-lane write of one 8-bit register
  function automatic logic [7:0] lane(input logic [7:0] addr, input logic [7:0] old);
    lane = old;
    if (byteenable[0] && address == addr) begin
      lane = writedata[7:0];
    end
  endfunction : lane

  // field decode
  assign run_control          = ctl_one[run_hi:run_lo];
  assign count_source_select  = ctl_one[src_hi:src_lo];
  assign function_select      = ctl_one[func_hi:func_lo];
  assign gate_pulse_select    = ctl_two[gsel_hi:gsel_lo];
  assign gate_irq_edge_select = ctl_two[gedge_bit];
  assign gate_clock_select    = ctl_two[gclk_hi:gclk_lo];
  assign slow_mode            = power_mode[1];
  assign measuring            = function_select[1];
  assign running              = (run_control == run_start); // RULE2
  // a write lands only at the edge where waitrequest is seen low
  assign wr_hit               = write && ack;
  assign waitrequest          = (read || write) && !ack;

  // count source multiplexer and its legality per power mode
  always_comb begin
    src_clk = 1'b0;
    src_ok  = 1'b1;
    case (count_source_select) // RULE3
      src_fast: begin
        src_clk = 1'b1;
        src_ok  = slow_mode ? (function_select == func_timer && power_mode == pm_slow)
                            : (function_select == func_pulse); // RULE7
      end
      3'h1: begin
        src_clk = fs_tick;
        src_ok  = !slow_mode;
      end
      3'h2, 3'h3, 3'h4: src_clk = div_tap[count_source_select - 3'h2];
      src_fast_d7, src_fast_d3: begin
        src_clk = div_tap[count_source_select - 3'h2];
        src_ok  = !slow_mode; // RULE12
      end
      src_event: src_clk = 1'b1;
      default: src_ok = 1'b0;
    endcase
  end

  // gate selection and gate time base
  always_comb begin
    gclk = (gate_clock_select == gclk_rsvd) ? 1'b0 : gate_tap[gate_clock_select]; // RULE17
    case (gate_pulse_select) // RULE15
      gate_pin: gate = pin_q;
      gate_int: gate = int_gate;
      default:  gate = 1'b0;
    endcase
  end

  assign gate_active_monitor = running && function_select == func_freq && gate_q; // RULE18

  // counting, gate pulse, registers and bus
  always_comb begin
    logic pin_fall;
    logic tick_rise;
    logic step;
    logic wrap;
    logic [7:0] pm_byte;
    pin_fall  = 1'b0;
    tick_rise = 1'b0;
    step      = 1'b0;
    wrap      = 1'b0;
    pm_byte   = 8'h00;
    next_ctl_one           = ctl_one;
    next_ctl_two           = ctl_two;
    next_gate_timing_value = gate_timing_value;
    next_compare_value     = compare_value;
    next_count             = count;
    next_overflow_monitor  = overflow_monitor;
    next_match_block       = match_block;
    next_power_mode        = power_mode;
    next_pin_q             = event_input_pin;
    next_tick_q            = src_clk;
    next_gate_q            = gate;
    next_gclk_q            = gclk;
    next_int_gate          = int_gate;
    next_gate_cnt          = gate_cnt;
    next_irq               = 1'b0;
    next_ack               = (read || write) && !ack;
    next_rdata             = rdata;
    pin_fall  = pin_q && !event_input_pin;
    tick_rise = src_clk && !tick_q;
    // internal window gate: high for 16-Ta ticks, low for 16-Tb ticks
    if (!running) begin
      next_int_gate = 1'b0;
      next_gate_cnt = 4'h0;
    end else if (gclk && !gclk_q) begin
      if (gate_cnt == 4'hf - (int_gate ? gate_timing_value[7:4] : gate_timing_value[3:0])) begin
        next_int_gate = !int_gate;
        next_gate_cnt = 4'h0;
      end else begin
        next_gate_cnt = gate_cnt + 4'h1;
      end
    end
    // count step per function
    if (running && src_ok) begin // RULE4
      case (function_select)
        func_timer: step = (count_source_select == src_event) ? pin_fall
                         : (count_source_select == src_fast) ? 1'b1 : tick_rise;
        func_pulse: step = pin_q && ((count_source_select == src_fast) ? 1'b1 : tick_rise);
        func_freq:  step = gate_q && pin_fall;
        default:    step = 1'b0;
      endcase
    end
    if (step) begin
      if (!measuring && !match_block && count + 18'h1 == compare_value) begin
        next_count = 18'h0; // RULE21
        next_irq   = 1'b1;
      end else begin
        next_count = count + 18'h1;
        if (measuring && count == 18'h3ffff) begin
          wrap                  = 1'b1;
          next_overflow_monitor = 1'b1; // RULE20
        end
      end
    end
    // gate edge interrupt in measurement modes
    if (running && measuring) begin
      if (gate_q && !gate) next_irq = 1'b1; // RULE22
      if (!gate_q && gate && gate_irq_edge_select) next_irq = 1'b1; // RULE16
    end
    if (!running) begin
      next_count = 18'h0; // RULE2
    end
    // register writes
    if (wr_hit) begin
      next_ctl_one = lane(ctl_one_addr, ctl_one);
      next_ctl_two = lane(ctl_two_addr, ctl_two);
      next_gate_timing_value = lane(gate_timing_addr, gate_timing_value);
      pm_byte = lane(power_addr, {6'h00, power_mode});
      next_power_mode = pm_byte[1:0];
      if (byteenable[0] && address == cmp_low_addr) begin
        next_compare_value[7:0] = writedata[7:0];
        next_match_block = 1'b1; // RULE6
      end
      if (byteenable[0] && address == cmp_mid_addr) begin
        next_compare_value[15:8] = writedata[7:0];
        next_match_block = 1'b1; // RULE6
      end
      if (byteenable[0] && address == cmp_high_addr) begin
        next_compare_value[17:16] = writedata[1:0]; // RULE13
        next_match_block = 1'b0;
      end
    end
    // clear bit: write of zero clears, then returns to one
    if (!ctl_one[clear_bit]) begin
      next_count            = 18'h0; // RULE1
      // a wrap in the same cycle wins over the clear
      next_overflow_monitor = wrap;
      next_ctl_one[clear_bit] = 1'b1;
    end
    // read data
    if (read && !ack) begin
      case (address)
        cmp_low_addr:     next_rdata = {24'h0, count[7:0]}; // RULE8
        cmp_mid_addr:     next_rdata = {24'h0, count[15:8]};
        cmp_high_addr:    next_rdata = {30'h0, count[17:16]}; // RULE13
        gate_timing_addr: next_rdata = {24'h0, gate_timing_value};
        ctl_one_addr:     next_rdata = {24'h0, ctl_one};
        ctl_two_addr:     next_rdata = {24'h0, ctl_two};
        status_addr:      next_rdata = {24'h0, gate_active_monitor, overflow_monitor,
                                        6'h00}; // RULE19
        power_addr:       next_rdata = {30'h0, power_mode};
        default:          next_rdata = 32'h0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_one           <= ctl_one_reset;
      ctl_two           <= ctl_two_reset;
      gate_timing_value <= gate_timing_reset;
      compare_value     <= 18'h0;
      count             <= 18'h0;
      overflow_monitor  <= 1'b0;
      match_block       <= 1'b0;
      power_mode        <= pm_normal;
      gate_q            <= 1'b0;
      tick_q            <= 1'b0;
      pin_q             <= 1'b0;
      int_gate          <= 1'b0;
      gate_cnt          <= 4'h0;
      gclk_q            <= 1'b0;
      irq               <= 1'b0;
      rdata             <= 32'h0;
      ack               <= 1'b0;
    end else begin
      ctl_one           <= next_ctl_one;
      ctl_two           <= next_ctl_two;
      gate_timing_value <= next_gate_timing_value;
      compare_value     <= next_compare_value;
      count             <= next_count;
      overflow_monitor  <= next_overflow_monitor;
      match_block       <= next_match_block;
      power_mode        <= next_power_mode;
      gate_q            <= next_gate_q;
      tick_q            <= next_tick_q;
      pin_q             <= next_pin_q;
      int_gate          <= next_int_gate;
      gate_cnt          <= next_gate_cnt;
      gclk_q            <= next_gclk_q;
      irq               <= next_irq;
      rdata             <= next_rdata;
      ack               <= next_ack;
    end
  end

  assign readdata    = rdata;
  assign counter_irq = irq;

endmodule : counter_ctl
`default_nettype wire

// ### bench/counter_ctl_chk.sv
// assertion checker for the counter control block
`default_nettype none
module counter_ctl_chk
  import counter_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // taps, pin and interrupt
  input wire logic        fs_tick,
  input wire logic [4:0]  div_tap,
  input wire logic [2:0]  gate_tap,
  input wire logic        event_input_pin,
  input wire logic        divider_stage_select,
  input wire logic        counter_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic rd_ack;
  // a read completing in this cycle
  assign rd_ack = read && !waitrequest;
  // bus handshake and read data
  a_wait_single: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  a_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised without a request");
  a_read_hold: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_ack && address == 8'h17 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  // register contents
  a_status_zero: assert property (rd_ack && address == status_addr |-> readdata[5:0] == 6'h0)
    else $error("status spare bits not zero");
  a_cmp_high_zero: assert property (rd_ack && address == cmp_high_addr |-> readdata[7:2] == 6'h0)
    else $error("compare high upper bits not zero");
  a_clear_reads_one: assert property (rd_ack && address == ctl_one_addr |-> readdata[clear_bit])
    else $error("clear bit did not return to one");
  // interrupt pulse
  a_irq_single: assert property (counter_irq |=> !counter_irq)
    else $error("interrupt longer than one cycle");
  // main scenarios
  c_read_ack: cover property (rd_ack);
  c_write_ack: cover property (write && !waitrequest);
  c_irq: cover property (counter_irq);
endmodule : counter_ctl_chk
bind counter_ctl counter_ctl_chk chk_i (.sys_clk, .nrst, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .fs_tick, .div_tap, .gate_tap, .event_input_pin,
  .divider_stage_select, .counter_irq);
`default_nettype wire

// ### bench/event_source.sv
// behavioural pulse source on the event input pin
`default_nettype none
module event_source (
  // clock and pin
  input  wire logic sys_clk,
  output var  logic event_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin idles low between bursts
  initial event_input_pin = 1'b0;
  // n pulses, each level held len cycles (len >= 2)
  task automatic pulse(input int n, input int len);
    repeat (n) begin
      @(posedge sys_clk);
      event_input_pin <= 1'b1;
      repeat (len) @(posedge sys_clk);
      event_input_pin <= 1'b0;
      repeat (len - 1) @(posedge sys_clk);
    end
  endtask : pulse
endmodule : event_source
`default_nettype wire

// ### bench/counter_ctl_tb_top.sv
// self-checking bench for the counter control block
`default_nettype none
module counter_ctl_tb_top
  import counter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, nrst = 0, read = 0, write = 0, fs_tick = 0;
  logic        divider_stage_select = 0, waitrequest, counter_irq, event_input_pin;
  logic [7:0]  address = 8'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0]  byteenable = 4'h1;
  logic [4:0]  div_tap = 5'h0;
  logic [2:0]  gate_tap = 3'h0;
  int          failures = 0, samples_checked = 0, irq_cnt = 0;
  counter_ctl DUT (.sys_clk, .nrst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .fs_tick, .div_tap, .gate_tap, .event_input_pin,
    .divider_stage_select, .counter_irq);
  event_source ev (.sys_clk, .event_input_pin);
  // clock
  initial forever #4 sys_clk = ~sys_clk;
  // free-running clock taps
  always @(posedge sys_clk) begin
    div_tap <= div_tap + 5'h1;
    gate_tap <= gate_tap + 3'h1;
    fs_tick <= div_tap[4];
  end
  // interrupt pulse counter
  always @(posedge sys_clk) if (counter_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  // compare and report
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // one bus transfer, held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge sys_clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    if (waitrequest !== 1'b0) begin
      failures++;
      final_report();
    end else begin
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h0, q);
    check({24'h0, q}, {24'h0, exp});
  endtask : rd_chk
  // reset values and an unmapped place
  task reset_values;
    rd_chk(ctl_one_addr, ctl_one_reset);
    rd_chk(ctl_two_addr, ctl_two_reset);
    rd_chk(status_addr, status_reset);
    rd_chk(cmp_high_addr, 8'h00);
    rd_chk(8'h17, 8'h00);
  endtask : reset_values
  // event counting against compare 3, then a half-written compare
  task event_match;
    wr(power_addr, 8'h00);
    wr(cmp_low_addr, 8'h03);
    wr(cmp_mid_addr, 8'h00);
    wr(cmp_high_addr, 8'h00);
    wr(ctl_one_addr, 8'h9c);
    wr(ctl_one_addr, 8'hdc);
    ev.pulse(7, 2);
    repeat (4) @(posedge sys_clk);
    check(32'(irq_cnt), 32'h2);
    rd_chk(cmp_low_addr, 8'h01);
    wr(cmp_low_addr, 8'h02);
    ev.pulse(3, 5);
    repeat (4) @(posedge sys_clk);
    check(32'(irq_cnt), 32'h2);
    rd_chk(cmp_low_addr, 8'h04);
  endtask : event_match
  // clear while running, then stop
  task clear_stop;
    wr(cmp_high_addr, 8'hff);
    wr(ctl_one_addr, 8'h5c);
    rd_chk(cmp_low_addr, 8'h00);
    rd_chk(ctl_one_addr, 8'hdc);
    ev.pulse(2, 2);
    repeat (4) @(posedge sys_clk);
    rd_chk(cmp_low_addr, 8'h02);
    wr(ctl_one_addr, 8'h9c);
    rd_chk(cmp_low_addr, 8'h00);
  endtask : clear_stop
  // fast taps by power mode, undivided fast clock in timer mode
  task source_modes;
    logic [7:0] q;
    wr(power_addr, 8'h02);
    wr(ctl_one_addr, 8'h94);
    wr(ctl_one_addr, 8'hd4);
    repeat (200) @(posedge sys_clk);
    rd_chk(cmp_low_addr, 8'h00);
    wr(ctl_one_addr, 8'h94);
    wr(power_addr, 8'h00);
    wr(ctl_one_addr, 8'hd4);
    repeat (200) @(posedge sys_clk);
    bus(1'b0, cmp_low_addr, 8'h00, q);
    check({31'h0, q != 8'h00}, 32'h1);
    wr(ctl_one_addr, 8'h94);
    wr(ctl_one_addr, 8'h80);
    wr(ctl_one_addr, 8'hc0);
    repeat (50) @(posedge sys_clk);
    rd_chk(cmp_low_addr, 8'h00);
  endtask : source_modes
  // pulse width on the undivided fast clock, gate interrupt on both edges
  task pulse_width;
    wr(ctl_one_addr, 8'h80);
    wr(ctl_one_addr, 8'h82);
    wr(ctl_two_addr, 8'h12);
    rd_chk(ctl_two_addr, 8'h12);
    wr(ctl_one_addr, 8'hc2);
    ev.pulse(1, 5);
    repeat (4) @(posedge sys_clk);
    rd_chk(cmp_low_addr, 8'h05);
    check(32'(irq_cnt), 32'h4);
    rd_chk(status_addr, 8'h00);
  endtask : pulse_width
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    reset_values();
    event_match();
    clear_stop();
    source_modes();
    pulse_width();
    final_report();
  end
endmodule : counter_ctl_tb_top
`default_nettype wire
